// ---- shared/vdfc_regs.vh ----
// Register indices, field positions, reset values and constants of the
// video digitizer control block. Byte address = 4 * index on the bus.
`ifndef VDFC_REGS_VH
`define VDFC_REGS_VH

`define IDX_INPUT_CONFIG   8'h05
`define IDX_GAIN_RED       8'h06
`define IDX_GAIN_GREEN     8'h07
`define IDX_GAIN_BLUE      8'h08
`define IDX_OFFSET_RED     8'h09
`define IDX_OFFSET_GREEN   8'h0a
`define IDX_OFFSET_BLUE    8'h0b
`define IDX_OFFSET_LSBS    8'h0c
`define IDX_CLAMP_START_A  8'h14
`define IDX_CLAMP_START_B  8'h15
`define IDX_CLAMP_WIDTH    8'h16
`define IDX_BLACK_CTRL     8'h17
`define IDX_OUTPUT_FORMAT  8'h18
`define IDX_SAMPLE_PHASE   8'h19
`define IDX_CLAMP_EXTRA    8'h23
`define IDX_STATUS         8'h30
`define IDX_DAC_RED        8'h31
`define IDX_DAC_GREEN      8'h32
`define IDX_DAC_BLUE       8'h33

`define CFG_DC_COUPLED     1
`define CFG_COMPONENT      2
`define CFG_CLAMP_ON_COAST 5
`define BLC_DISABLE        0
`define FMT_LEGACY         3
`define FMT_422            4
`define STAT_OVERFLOW      7

`define RST_ZERO           8'h00
`define RST_GAIN           8'h55
`define RST_OFFSET         8'h80
`define RST_START_A        8'h00
`define RST_START_B        8'h10
`define RST_WIDTH          8'h08
`define OFFSET_NOMINAL     8'h80
`define SHIFT_LIMIT        8'h40
`define BLACK_RGB          8'h00
`define BLACK_CHROMA       8'h80
`define DAC_MID            10'h200
`define PHASE_W            6

`endif

// ---- logic/black_level_servo.v ----
// One channel of the black-level servo driving a 10-bit offset converter.
// Assumes measure pulses once per line and sample is the raw ADC code.
`include "vdfc_regs.vh"

module black_level_servo #(
  parameter DAC_W = 10
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Control
  input  wire             auto_en,
  input  wire             measure,
  input  wire [7:0]       sample,
  input  wire [7:0]       target,
  input  wire [DAC_W-1:0] manual,
  // State
  output reg  [DAC_W-1:0] dac_q,
  output reg              locked_q
);

  wire [DAC_W-1:0] dac_max = {DAC_W{1'b1}};

  // Increasing the converter code raises the digitized level.
  always @(posedge clk) begin
    if (!rst_n) begin
      dac_q    <= `DAC_MID;
      locked_q <= 1'b0;
    end else if (!auto_en) begin
      dac_q    <= manual;
      locked_q <= 1'b0;
    end else if (measure) begin
      if (sample > target) begin
        locked_q <= 1'b0;
        if (dac_q != {DAC_W{1'b0}})
          dac_q <= dac_q - 1'b1;
      end else if (sample < target) begin
        locked_q <= 1'b0;
        if (dac_q != dac_max)
          dac_q <= dac_q + 1'b1;
      end else begin
        locked_q <= 1'b1;
      end
    end
  end

endmodule // black_level_servo

// ---- logic/pixel_fifo.v ----
// Synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock; full and empty are exact.
module pixel_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];

  always @(posedge clk) begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule // pixel_fifo

// ---- logic/video_digitizer_format_and_clamp.v ----
// Digital control side of a three-channel video digitizer: registers,
// clamp timing, black-level servo, digital offset and output format.
// Assumes ADC samples arrive on MCLK; HSYNC_IN and COAST_IN are pins.
`include "vdfc_regs.vh"

module video_digitizer_format_and_clamp #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // Clock and reset
  input  wire        MCLK,
  input  wire        RESETN,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  // Front end
  input  wire [7:0]  ADC_R,
  input  wire [7:0]  ADC_G,
  input  wire [7:0]  ADC_B,
  input  wire        ACTIVE_IN,
  input  wire        HSYNC_IN,
  input  wire        COAST_IN,
  // Analog controls
  output reg  [7:0]  GAIN_R,
  output reg  [7:0]  GAIN_G,
  output reg  [7:0]  GAIN_B,
  output wire [9:0]  DAC_R,
  output wire [9:0]  DAC_G,
  output wire [9:0]  DAC_B,
  output reg         CLAMP_OUT,
  output reg         DC_COUPLED,
  output reg  [5:0]  SAMPLE_PHASE,
  // Pixel stream
  output reg  [7:0]  PIX_R,
  output reg  [7:0]  PIX_G,
  output reg  [7:0]  PIX_B,
  output reg         PIX_VALID,
  input  wire        PIX_READY
);

  // Registers.
  reg [7:0]  cfg_q;
  reg [7:0]  gain_r_q;
  reg [7:0]  gain_g_q;
  reg [7:0]  gain_b_q;
  reg [7:0]  off_r_q;
  reg [7:0]  off_g_q;
  reg [7:0]  off_b_q;
  reg [7:0]  off_lsb_q;
  reg [7:0]  start_a_q;
  reg [7:0]  start_b_q;
  reg [7:0]  width_q;
  reg [7:0]  blc_q;
  reg [7:0]  fmt_q;
  reg [7:0]  phase_q;
  reg [7:0]  extra_q;
  reg        ovf_q;

  // Bus state.
  reg        wr_pend_q;
  reg        rd_pend_q;
  reg [7:0]  addr_q;
  reg [31:0] rd_val;

  // Line timing.
  reg        hs_s1_q;
  reg        hs_s2_q;
  reg        hs_s3_q;
  reg        co_s1_q;
  reg        co_s2_q;
  reg        line_coast_q;
  reg [15:0] pix_cnt_q;
  reg [7:0]  win_cnt_q;
  reg        win_q;
  reg        win_d;
  reg        measure_q;

  // Pixel path.
  reg [7:0]  r1_q;
  reg [7:0]  g1_q;
  reg [7:0]  b1_q;
  reg        act1_q;
  reg        act_prev_q;
  reg        odd1_q;
  reg        last_odd_q;
  reg [7:0]  v_hold_q;
  reg [23:0] fmt_data;

  wire [2:0] locked;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [23:0] fifo_out_data;

  wire       take     = HSEL & HTRANS[1] & HREADY;
  wire       trail    = hs_s3_q & ~hs_s2_q;
  wire       auto_en  = ~blc_q[`BLC_DISABLE];
  wire       coast_ok = cfg_q[`CFG_CLAMP_ON_COAST] | ~line_coast_q;
  wire [15:0] start   = {start_a_q, start_b_q};
  wire       comp     = cfg_q[`CFG_COMPONENT];
  wire [7:0] chroma_black = comp ? `BLACK_CHROMA : `BLACK_RGB;
  wire       first    = ACTIVE_IN & ~act_prev_q;
  wire       fifo_take = ~PIX_VALID | PIX_READY;

  // Offset shift, limited to the documented span, saturated to 8 bits.
  function [7:0] shift_px;
    input [7:0] px;
    input [7:0] off;
    integer sh;
    integer sm;
    integer lim;
    begin
      // Signed integers throughout, so a low offset shifts downwards.
      lim = `SHIFT_LIMIT;
      sh  = off;
      sh  = sh - `OFFSET_NOMINAL;
      if (sh > lim)
        sh = lim;
      if (sh < -lim)
        sh = -lim;
      sm = px + sh;
      if (sm < 0)
        sm = 0;
      if (sm > 255)
        sm = 255;
      shift_px = sm[7:0];
    end
  endfunction

  // Register file and AHB-Lite slave. Reads take one wait state so that
  // a read right behind a write to the same register sees the new value.
  always @(posedge MCLK) begin
    if (!RESETN) begin
      cfg_q     <= `RST_ZERO;
      gain_r_q  <= `RST_GAIN;
      gain_g_q  <= `RST_GAIN;
      gain_b_q  <= `RST_GAIN;
      off_r_q   <= `RST_OFFSET;
      off_g_q   <= `RST_OFFSET;
      off_b_q   <= `RST_OFFSET;
      off_lsb_q <= `RST_ZERO;
      start_a_q <= `RST_START_A;
      start_b_q <= `RST_START_B;
      width_q   <= `RST_WIDTH;
      blc_q     <= `RST_ZERO;
      fmt_q     <= `RST_ZERO;
      phase_q   <= `RST_ZERO;
      extra_q   <= `RST_ZERO;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= `RST_ZERO;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      wr_pend_q <= take & HWRITE;
      rd_pend_q <= take & ~HWRITE;
      HREADYOUT <= ~(take & ~HWRITE);
      if (take)
        addr_q <= HADDR[9:2];
      if (rd_pend_q)
        HRDATA <= rd_val;
      if (wr_pend_q) begin
        case (addr_q)
          `IDX_INPUT_CONFIG:  cfg_q     <= HWDATA[7:0];
          `IDX_GAIN_RED:      gain_r_q  <= HWDATA[7:0];
          `IDX_GAIN_GREEN:    gain_g_q  <= HWDATA[7:0];
          `IDX_GAIN_BLUE:     gain_b_q  <= HWDATA[7:0];
          `IDX_OFFSET_RED:    off_r_q   <= HWDATA[7:0];
          `IDX_OFFSET_GREEN:  off_g_q   <= HWDATA[7:0];
          `IDX_OFFSET_BLUE:   off_b_q   <= HWDATA[7:0];
          `IDX_OFFSET_LSBS:   off_lsb_q <= HWDATA[7:0];
          `IDX_CLAMP_START_A: start_a_q <= HWDATA[7:0];
          `IDX_CLAMP_START_B: start_b_q <= HWDATA[7:0];
          `IDX_CLAMP_WIDTH:   width_q   <= HWDATA[7:0];
          `IDX_BLACK_CTRL:    blc_q     <= HWDATA[7:0];
          `IDX_OUTPUT_FORMAT: fmt_q     <= HWDATA[7:0];
          `IDX_SAMPLE_PHASE:  phase_q   <= HWDATA[7:0];
          `IDX_CLAMP_EXTRA:   extra_q   <= HWDATA[7:0];
          default: ;
        endcase
      end
    end
  end

  always @* begin
    rd_val = 32'h0000_0000;
    case (addr_q)
      `IDX_INPUT_CONFIG:  rd_val[7:0] = cfg_q;
      `IDX_GAIN_RED:      rd_val[7:0] = gain_r_q;
      `IDX_GAIN_GREEN:    rd_val[7:0] = gain_g_q;
      `IDX_GAIN_BLUE:     rd_val[7:0] = gain_b_q;
      `IDX_OFFSET_RED:    rd_val[7:0] = off_r_q;
      `IDX_OFFSET_GREEN:  rd_val[7:0] = off_g_q;
      `IDX_OFFSET_BLUE:   rd_val[7:0] = off_b_q;
      `IDX_OFFSET_LSBS:   rd_val[7:0] = off_lsb_q;
      `IDX_CLAMP_START_A: rd_val[7:0] = start_a_q;
      `IDX_CLAMP_START_B: rd_val[7:0] = start_b_q;
      `IDX_CLAMP_WIDTH:   rd_val[7:0] = width_q;
      `IDX_BLACK_CTRL:    rd_val[7:0] = blc_q;
      `IDX_OUTPUT_FORMAT: rd_val[7:0] = fmt_q;
      `IDX_SAMPLE_PHASE:  rd_val[7:0] = phase_q;
      `IDX_CLAMP_EXTRA:   rd_val[7:0] = extra_q;
      `IDX_STATUS:        rd_val[7:0] = {ovf_q, 4'h0, locked};
      `IDX_DAC_RED:       rd_val[9:0] = DAC_R;
      `IDX_DAC_GREEN:     rd_val[9:0] = DAC_G;
      `IDX_DAC_BLUE:      rd_val[9:0] = DAC_B;
      default:            rd_val = 32'h0000_0000;
    endcase
  end

  // Sticky overflow: a new overflow in the clearing cycle wins.
  always @(posedge MCLK) begin
    if (!RESETN)
      ovf_q <= 1'b0;
    else if (act1_q & ~fifo_in_ready)
      ovf_q <= 1'b1;
    else if (wr_pend_q && addr_q == `IDX_STATUS && HWDATA[`STAT_OVERFLOW])
      ovf_q <= 1'b0;
  end

  // The sync pin passes three flip-flops and the coast pin two; the edge detector looks only
  // at the second and third sync stages.
  always @(posedge MCLK) begin
    if (!RESETN) begin
      hs_s1_q <= 1'b0;
      hs_s2_q <= 1'b0;
      hs_s3_q <= 1'b0;
      co_s1_q <= 1'b0;
      co_s2_q <= 1'b0;
    end else begin
      hs_s1_q <= HSYNC_IN;
      hs_s2_q <= hs_s1_q;
      hs_s3_q <= hs_s2_q;
      co_s1_q <= COAST_IN;
      co_s2_q <= co_s1_q;
    end
  end

  // Window opens at the start count and lasts width pixels unless the sync trailing edge or a coast ends it first.
  always @* begin
    win_d = win_q;
    if (trail)
      win_d = 1'b0;
    else if (pix_cnt_q == start && width_q != `RST_ZERO && coast_ok)
      win_d = 1'b1;
    else if (win_q && win_cnt_q == 8'h01)
      win_d = 1'b0;
  end

  always @(posedge MCLK) begin
    if (!RESETN) begin
      pix_cnt_q    <= 16'h0000;
      line_coast_q <= 1'b0;
      win_q        <= 1'b0;
      win_cnt_q    <= `RST_ZERO;
      measure_q    <= 1'b0;
      CLAMP_OUT    <= 1'b0;
      DC_COUPLED   <= 1'b0;
    end else begin
      if (trail)
        pix_cnt_q <= 16'h0000;
      else if (pix_cnt_q != 16'hffff)
        pix_cnt_q <= pix_cnt_q + 1'b1;
      if (trail)
        line_coast_q <= co_s2_q;
      else if (co_s2_q)
        line_coast_q <= 1'b1;
      win_q <= win_d & coast_ok;
      if (~win_q & win_d)
        win_cnt_q <= width_q;
      else if (win_q)
        win_cnt_q <= win_cnt_q - 1'b1;
      measure_q  <= win_q & ~win_d & ~trail & coast_ok & auto_en;
      CLAMP_OUT  <= win_d & coast_ok & ~cfg_q[`CFG_DC_COUPLED];
      DC_COUPLED <= cfg_q[`CFG_DC_COUPLED];
    end
  end

  // Gains reach the amplifiers once per line, at the sync trailing edge.
  always @(posedge MCLK) begin
    if (!RESETN) begin
      GAIN_R       <= `RST_GAIN;
      GAIN_G       <= `RST_GAIN;
      GAIN_B       <= `RST_GAIN;
      SAMPLE_PHASE <= {`PHASE_W{1'b0}};
    end else begin
      if (trail) begin
        GAIN_R <= gain_r_q;
        GAIN_G <= gain_g_q;
        GAIN_B <= gain_b_q;
      end
      SAMPLE_PHASE <= phase_q[`PHASE_W-1:0];
    end
  end

  // Servo targets are fixed by mode only, so gain changes leave black alone.
  black_level_servo #(.DAC_W(10)) u_servo_r (
    .clk      (MCLK),
    .rst_n    (RESETN),
    .auto_en  (auto_en),
    .measure  (measure_q),
    .sample   (ADC_R),
    .target   (chroma_black),
    .manual   ({off_r_q, off_lsb_q[7:6]}),
    .dac_q    (DAC_R),
    .locked_q (locked[0])
  );

  black_level_servo #(.DAC_W(10)) u_servo_g (
    .clk      (MCLK),
    .rst_n    (RESETN),
    .auto_en  (auto_en),
    .measure  (measure_q),
    .sample   (ADC_G),
    .target   (`BLACK_RGB),
    .manual   ({off_g_q, off_lsb_q[5:4]}),
    .dac_q    (DAC_G),
    .locked_q (locked[1])
  );

  black_level_servo #(.DAC_W(10)) u_servo_b (
    .clk      (MCLK),
    .rst_n    (RESETN),
    .auto_en  (auto_en),
    .measure  (measure_q),
    .sample   (ADC_B),
    .target   (chroma_black),
    .manual   ({off_b_q, off_lsb_q[3:2]}),
    .dac_q    (DAC_B),
    .locked_q (locked[2])
  );

  // Stage one: digital offset, only while the servo owns the converters.
  always @(posedge MCLK) begin
    if (!RESETN) begin
      r1_q       <= `RST_ZERO;
      g1_q       <= `RST_ZERO;
      b1_q       <= `RST_ZERO;
      act1_q     <= 1'b0;
      act_prev_q <= 1'b0;
      odd1_q     <= 1'b0;
      last_odd_q <= 1'b0;
    end else begin
      r1_q <= auto_en ? shift_px(ADC_R, off_r_q) : ADC_R;
      g1_q <= auto_en ? shift_px(ADC_G, off_g_q) : ADC_G;
      b1_q <= auto_en ? shift_px(ADC_B, off_b_q) : ADC_B;
      act1_q     <= ACTIVE_IN;
      act_prev_q <= ACTIVE_IN;
      if (ACTIVE_IN) begin
        odd1_q     <= first ? 1'b0 : ~last_odd_q;
        last_odd_q <= first ? 1'b0 : ~last_odd_q;
      end
    end
  end

  // Holds V of the even pixel for the odd slot of standard ordering.
  always @(posedge MCLK) begin
    if (!RESETN)
      v_hold_q <= `RST_ZERO;
    else if (act1_q & ~odd1_q)
      v_hold_q <= r1_q;
  end

  // Component values pass as digitized: Y green, U blue, V red.
  always @* begin
    fmt_data = {r1_q, g1_q, b1_q};
    if (fmt_q[`FMT_422]) begin
      fmt_data[15:8] = g1_q;
      fmt_data[7:0]  = 8'h00;
      if (~odd1_q)
        fmt_data[23:16] = b1_q;
      else if (fmt_q[`FMT_LEGACY])
        fmt_data[23:16] = r1_q;
      else
        fmt_data[23:16] = v_hold_q;
    end
  end

  // The front end cannot be stalled; a full FIFO drops the pixel and sets
  // the sticky overflow bit instead.
  pixel_fifo #(
    .WIDTH (24),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (MCLK),
    .rst_n     (RESETN),
    .in_valid  (act1_q),
    .in_ready  (fifo_in_ready),
    .in_data   (fmt_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_out_data)
  );

  always @(posedge MCLK) begin
    if (!RESETN) begin
      PIX_VALID <= 1'b0;
      PIX_R     <= `RST_ZERO;
      PIX_G     <= `RST_ZERO;
      PIX_B     <= `RST_ZERO;
    end else if (fifo_take) begin
      PIX_VALID <= fifo_out_valid;
      PIX_R     <= fifo_out_data[23:16];
      PIX_G     <= fifo_out_data[15:8];
      PIX_B     <= fifo_out_data[7:0];
    end
  end

endmodule // video_digitizer_format_and_clamp

// ---- tb/vdfc_chk.sv ----
// Checker of bus, clamp and pixel-stream relations of the digitizer top.
// Assumes a bind to the top; registers it needs are shadowed from writes.
module vdfc_chk (
  // Clock, reset and bus
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // Front end and controls
  input wire logic        COAST_IN,
  input wire logic [9:0]  DAC_G,
  input wire logic        CLAMP_OUT,
  input wire logic        DC_COUPLED,
  // Pixel stream
  input wire logic [7:0]  PIX_R,
  input wire logic [7:0]  PIX_G,
  input wire logic [7:0]  PIX_B,
  input wire logic        PIX_VALID,
  input wire logic        PIX_READY
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wph_q;
  logic [7:0] widx_q;
  logic [7:0] cfg_q;
  logic [7:0] wid_q;
  logic [7:0] blc_q;
  logic [7:0] fmt_q;
  logic [8:0] cnt_q;

  // Shadows change at the end of the data phase, as the slave's own do.
  always_ff @(posedge MCLK) begin
    if (HSEL && HTRANS[1] && HREADY) widx_q <= HADDR[9:2];
    cnt_q <= CLAMP_OUT ? cnt_q + 9'h001 : 9'h000;
    if (!RESETN) begin
      wph_q <= 1'b0;
      cfg_q <= 8'h00;
      wid_q <= 8'h08;
      blc_q <= 8'h00;
      fmt_q <= 8'h00;
    end else begin
      wph_q <= HSEL && HTRANS[1] && HREADY && HWRITE;
      if (wph_q && HREADY) begin
        case (widx_q)
          8'h05: cfg_q <= HWDATA[7:0];
          8'h16: wid_q <= HWDATA[7:0];
          8'h17: blc_q <= HWDATA[7:0];
          8'h18: fmt_q <= HWDATA[7:0];
          default: ;
        endcase
      end
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  sequence rd_take; HSEL && HTRANS[1] && HREADY && !HWRITE; endsequence
  sequence wr_take; HSEL && HTRANS[1] && HREADY && HWRITE; endsequence
  sequence one_wait; !HREADYOUT ##1 HREADYOUT; endsequence

  chk_bus_okay: assert property (HRESP == 1'b0)
    else $error("bus response not OKAY");
  chk_read_wait: assert property (rd_take |=> one_wait)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (wr_take |=> HREADYOUT)
    else $error("write stalled");
  chk_pix_hold: assert property (PIX_VALID && !PIX_READY
    |=> PIX_VALID && $stable({PIX_R, PIX_G, PIX_B}))
    else $error("pixel word changed before taken");
  chk_blue_low: assert property (PIX_VALID && fmt_q[4] |-> PIX_B == 8'h00)
    else $error("blue not low in 4:2:2");
  chk_clamp_dc: assert property ($rose(CLAMP_OUT) |-> !DC_COUPLED)
    else $error("clamp applied while DC coupled");
  chk_clamp_width: assert property ($fell(CLAMP_OUT) |-> cnt_q == {1'b0, wid_q})
    else $error("clamp width wrong");
  chk_clamp_coast: assert property ($rose(CLAMP_OUT) |-> cfg_q[5] || !$past(COAST_IN, 4))
    else $error("clamp applied while coasting");
  chk_dac_step: assert property (!blc_q[0] && !$past(blc_q[0]) && $changed(DAC_G)
    |-> DAC_G == $past(DAC_G) + 10'h001 || DAC_G == $past(DAC_G) - 10'h001)
    else $error("servo step not one code");
endmodule // vdfc_chk

// ---- tb/pixel_sink.sv ----
// Downstream processor model taking pixel words with valid and ready.
// Assumes mode 0 always ready, 1 random stalls, 2 stalls throughout.
module pixel_sink (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [23:0] word,
  input  wire logic        valid,
  output logic             ready,
  input  wire logic [1:0]  mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] got[$];
  int          seed = 32'hb32a;

  initial ready = 1'b0;
  always @(posedge clk) begin
    if (rst_n && valid && ready) got.push_back(word);
    ready <= rst_n && (mode == 2'd0 || (mode == 2'd1 && $random(seed) % 2 != 0));
  end
endmodule // pixel_sink

// ---- tb/tb_top.sv ----
// Self-checking bench of the video digitizer control block.
// Assumes the checker, the pixel sink and the design compile beside it.
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t: got %h expected %h", $time, (a), (e)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'b00;
  logic        HWRITE = 1'b0;
  logic [2:0]  HSIZE = 3'b010;
  logic [31:0] HWDATA = 32'h0;
  wire  [31:0] HRDATA;
  wire         HREADYOUT, HRESP;
  wire         HREADY = HREADYOUT;
  logic [7:0]  ADC_R = 8'h00, ADC_G = 8'h05, ADC_B = 8'h00;
  logic        ACTIVE_IN = 1'b0, HSYNC_IN = 1'b0, COAST_IN = 1'b0;
  wire  [7:0]  GAIN_R, GAIN_G, GAIN_B, PIX_R, PIX_G, PIX_B;
  wire  [9:0]  DAC_R, DAC_G, DAC_B;
  wire         CLAMP_OUT, DC_COUPLED, PIX_VALID, PIX_READY;
  wire  [5:0]  SAMPLE_PHASE;
  logic [1:0]  smode = 2'd0;
  logic [7:0]  pr[16], pg[16], pb[16], off[3], st, w, g;
  logic [31:0] r;
  logic [9:0]  d0;
  logic        mv, cl;
  int          seed = 32'hb32a, miscompares = 0, n_tests = 0, cyc = 0;
  int          rise, hi, base;

  video_digitizer_format_and_clamp dut_u (.*);
  pixel_sink snk_u (.clk(MCLK), .rst_n(RESETN), .word({PIX_R, PIX_G, PIX_B}),
                    .valid(PIX_VALID), .ready(PIX_READY), .mode(smode));

  initial forever #2 MCLK = ~MCLK;

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A hang anywhere in the sequence lands here instead of running forever.
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test;
    end
  end

  function automatic logic [7:0] rnd8();
    return 8'($random(seed));
  endfunction

  task automatic bus(input logic wr, input logic [7:0] i, d);
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR <= {22'h0, i, 2'b00};
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= {24'h0, d};
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask

  task automatic wr(input logic [7:0] i, d);
    bus(1'b1, i, d);
  endtask

  // Sync pulse, then the clamp is sampled just after each edge.
  task automatic line();
    HSYNC_IN <= 1'b1;
    repeat (4) @(posedge MCLK);
    HSYNC_IN <= 1'b0;
    rise = 0;
    hi = 0;
    for (int k = 1; k < 40; k++) begin
      @(posedge MCLK);
      #1;
      if (CLAMP_OUT === 1'b1) begin
        hi++;
        if (rise == 0) rise = k;
      end
    end
  endtask

  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge MCLK);
      pr[i] = rnd8();
      pg[i] = rnd8();
      pb[i] = rnd8();
      ADC_R <= pr[i];
      ADC_G <= pg[i];
      ADC_B <= pb[i];
      ACTIVE_IN <= 1'b1;
    end
    @(posedge MCLK);
    ACTIVE_IN <= 1'b0;
  endtask

  function automatic logic [7:0] shf(input logic [7:0] a, o);
    int s;
    s = int'(o) - 128;
    if (s > 64) s = 64;
    if (s < -64) s = -64;
    s += int'(a);
    return (s < 0) ? 8'h00 : (s > 255) ? 8'hff : 8'(s);
  endfunction

  function automatic logic [23:0] px_exp(input int i, input logic [7:0] fm);
    logic [7:0] u;
    if (!fm[4]) return {shf(pr[i], off[0]), shf(pg[i], off[1]), shf(pb[i], off[2])};
    u = (i % 2 == 0) ? shf(pb[i], off[2]) : shf(pr[fm[3] ? i : i - 1], off[0]);
    return {u, shf(pg[i], off[1]), 8'h00};
  endfunction

  logic [7:0] ri[10] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h14, 8'h15, 8'h16,
                         8'h18, 8'h23, 8'h3f};
  logic [7:0] rv[10] = '{8'h00, 8'h55, 8'h55, 8'h55, 8'h00, 8'h10, 8'h08,
                         8'h00, 8'h00, 8'h00};
  logic [7:0] cf[4] = '{8'h00, 8'h00, 8'h20, 8'h02};
  logic       co[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0] fc[4] = '{8'h00, 8'h04, 8'h04, 8'h04};
  logic [7:0] ff[4] = '{8'h00, 8'h00, 8'h10, 8'h18};

  initial begin
    repeat (5) @(posedge MCLK);
    RESETN <= 1'b1;
    `CHK(GAIN_G, 8'h55)
    `CHK(DAC_B, 10'h200)
    wr(8'h3f, 8'haa);
    foreach (ri[k]) begin
      bus(1'b0, ri[k], 8'h00);
      `CHK(r, {24'h0, rv[k]})
    end
    wr(8'h19, 8'h3f);
    repeat (3) @(posedge MCLK);
    `CHK(SAMPLE_PHASE, 6'h3f)
    g = rnd8();
    wr(8'h06, g);
    bus(1'b0, 8'h06, 8'h00);
    `CHK(r[7:0], g)
    foreach (cf[k]) begin
      st = 8'h04 + rnd8() % 8'h0c;
      w = 8'h01 + rnd8() % 8'h08;
      wr(8'h15, st);
      wr(8'h16, w);
      wr(8'h05, cf[k]);
      COAST_IN <= co[k];
      d0 = DAC_G;
      line();
      mv = !(co[k] && !cf[k][5]);
      cl = mv && !cf[k][1];
      if (k == 0) base = rise - int'(st);
      `CHK(hi, cl ? int'(w) : 0)
      if (cl) `CHK(rise - int'(st), base)
      `CHK(DAC_G, mv ? d0 - 10'h001 : d0)
      `CHK(DC_COUPLED, cf[k][1])
    end
    `CHK(base inside {3, 4}, 1'b1)
    `CHK(GAIN_R, g)
    `CHK(GAIN_B, 8'h55)
    COAST_IN <= 1'b0;
    wr(8'h17, 8'h01);
    wr(8'h0a, 8'h33);
    wr(8'h0c, 8'ha8);
    repeat (3) @(posedge MCLK);
    `CHK(DAC_G, 10'h0ce)
    `CHK(DAC_R, 10'h202)
    `CHK(DAC_B, 10'h202)
    wr(8'h05, 8'h00);
    line();
    `CHK(DAC_G, 10'h0ce)
    wr(8'h17, 8'h00);
    off[0] = 8'h00;
    off[1] = rnd8();
    off[2] = 8'hff;
    wr(8'h09, off[0]);
    wr(8'h0a, off[1]);
    wr(8'h0b, off[2]);
    smode <= 2'd1;
    foreach (ff[f]) begin
      wr(8'h05, fc[f]);
      wr(8'h18, ff[f]);
      repeat (2) begin
        line();
        burst(7);
        while (snk_u.got.size() < 7) @(posedge MCLK);
        for (int i = 0; i < 7; i++) begin
          `CHK(snk_u.got[i], px_exp(i, ff[f]))
        end
        snk_u.got.delete();
      end
    end
    ADC_R <= 8'h80;
    ADC_G <= 8'h00;
    ADC_B <= 8'h80;
    wr(8'h05, 8'h04);
    line();
    bus(1'b0, 8'h30, 8'h00);
    `CHK(r[2:0], 3'b111)
    wr(8'h05, 8'h00);
    wr(8'h18, 8'h00);
    smode <= 2'd2;
    burst(12);
    repeat (8) @(posedge MCLK);
    bus(1'b0, 8'h30, 8'h00);
    `CHK(r[7], 1'b1)
    smode <= 2'd1;
    repeat (60) @(posedge MCLK);
    `CHK(snk_u.got.size() < 12, 1'b1)
    `CHK(snk_u.got[0], px_exp(0, 8'h00))
    `CHK(PIX_VALID, 1'b0)
    wr(8'h30, 8'h80);
    bus(1'b0, 8'h30, 8'h00);
    `CHK(r[7], 1'b0)
    stop_test;
  end
endmodule // tb_top

bind video_digitizer_format_and_clamp vdfc_chk chk_u (.*);
